// ---- logic/ume_ext.sv ----
// Mode extension, interrupt vectors and register file of the serial transceiver.
// Assumes a core frame engine that shifts bits, makes baud ticks and reports events.
`timescale 1ns/1ps
`default_nettype none
module ume_ext
    import ume_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic        rxd_pin_in,
    input  wire logic        event_rx_in,
    output logic             txd_pin_out,
    output logic             txd_pin_oe,
    // Core receive side
    output logic             core_rxd,
    input  wire logic        core_rx_valid,
    input  wire logic [8:0]  core_rx_data,
    input  wire logic        core_rx_stop1,
    input  wire logic        core_rx_perr,
    input  wire logic        core_rx_start,
    input  wire logic        core_autobaud_err,
    input  wire logic        core_bad_sync,
    input  wire logic        core_break,
    // Core transmit side
    input  wire logic        core_txd,
    input  wire logic        core_tx_ready,
    input  wire logic        core_tx_done,
    input  wire logic        core_tx_bit_start,
    input  wire logic        core_os_tick,
    output logic             core_tx_load,
    output logic [8:0]       core_tx_data,
    // Core configuration
    output logic             rx_enable,
    output logic             tx_enable,
    output logic             start_detect_en,
    output logic             double_speed,
    output logic [2:0]       char_size_field,
    output logic             two_stop,
    output logic [1:0]       parity_mode,
    output logic [15:0]      baud_divisor,
    output logic             run_in_debug,
    input  wire logic        tx_done_ack,
    // Interrupt vectors
    output logic             rx_complete_vector,
    output logic             tx_empty_vector,
    output logic             tx_done_vector
);
    logic [7:0]  irq_enable_control;
    logic [7:0]  rx_tx_control;
    logic [7:0]  frame_format_control;
    logic [7:0]  debug_run_control;
    logic [7:0]  event_input_control;
    logic [7:0]  ir_tx_pulse_length;
    logic [6:0]  ir_rx_pulse_length;
    logic        tx_data_high;
    logic [8:0]  tx_buf;
    logic        tx_buf_full;
    logic        tx_done_flag;
    logic        rx_start_flag;
    logic        bad_sync_flag;
    logic        break_flag;
    logic        wait_break;
    logic [11:0] rx_buf [2];
    logic [1:0]  rx_count;
    logic        bus_ack;
    logic [7:0]  next_rdata;
    logic        req;
    logic        wr_go;
    logic        rd_go;
    logic [3:0]  idx;
    logic [7:0]  wbyte;
    logic        multiproc_filter_mode;
    logic        infrared_mode;
    logic        infrared_event_input_en;
    logic        frame_type;
    logic        rx_accept;
    logic        rx_pop;
    logic        rx_complete_flag;
    logic        tx_empty_flag;
    logic        raw_rx;
    logic        dec_rx;
    logic        ir_pin_tx;

    // Bus slave: one wait cycle so read data is registered before the answer
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !bus_ack;
    assign idx             = avs_address[5:2];
    assign wbyte           = avs_writedata[7:0];
    assign wr_go           = avs_write && bus_ack && avs_byteenable[0];
    assign rd_go           = avs_read && bus_ack;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            bus_ack <= 1'b0;
        else
            bus_ack <= req && !bus_ack;
    end

    // Mode decode
    assign multiproc_filter_mode   = rx_tx_control[CB_MULTIPROC];
    assign infrared_mode           = frame_format_control[FC_COMM_MODE_FIELD_LSB +: 2] == COMM_MODE_FIELD_INFRARED;
    assign infrared_event_input_en = event_input_control[EV_INFRARED_IN];

    assign rx_enable       = rx_tx_control[CB_RX_EN];
    assign tx_enable       = rx_tx_control[CB_TX_EN];
    assign start_detect_en = rx_tx_control[CB_START_DET];
    assign double_speed    = (rx_tx_control[CB_RXMODE_LSB +: 2] == RXMODE_DOUBLE) && !infrared_mode;
    assign char_size_field = frame_format_control[2:0];
    assign two_stop        = frame_format_control[FC_TWO_STOP];
    assign parity_mode     = frame_format_control[FC_PMODE_LSB +: 2];
    assign run_in_debug    = debug_run_control[DBG_RUN];

    // Control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_enable_control   <= 8'h00;
            rx_tx_control        <= 8'h00;
            frame_format_control <= 8'h00;
            baud_divisor         <= 16'h0000;
            debug_run_control    <= 8'h00;
            event_input_control  <= 8'h00;
            ir_tx_pulse_length   <= 8'h00;
            ir_rx_pulse_length   <= 7'h00;
            tx_data_high         <= 1'b0;
        end else if (wr_go) begin
            unique case (idx)
                IDX_IRQ_EN_CTRL: irq_enable_control   <= wbyte;
                IDX_RX_TX_CTRL:  rx_tx_control        <= wbyte;
                IDX_FRAME_CTRL:  frame_format_control <= wbyte;
                IDX_BAUD_LOW:    baud_divisor[7:0]    <= wbyte;
                IDX_BAUD_HIGH:   baud_divisor[15:8]   <= wbyte;
                IDX_DEBUG_CTRL:  debug_run_control    <= {7'h00, wbyte[DBG_RUN]};
                IDX_EVENT_CTRL:  event_input_control  <= {7'h00, wbyte[EV_INFRARED_IN]};
                IDX_IR_TX_PULSE: ir_tx_pulse_length   <= wbyte;
                IDX_IR_RX_PULSE: ir_rx_pulse_length   <= wbyte[6:0];
                IDX_TX_DATA_HIGH: tx_data_high        <= wbyte[0];
                default: ;
            endcase
        end
    end

    // Transmit buffer: one character waiting for the shift register
    assign tx_empty_flag = !tx_buf_full;
    assign core_tx_load  = tx_buf_full && core_tx_ready && tx_enable;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_buf      <= 9'h000;
            tx_buf_full <= 1'b0;
        end else if (!tx_enable) begin
            tx_buf_full <= 1'b0;
        end else if (wr_go && idx == IDX_TX_DATA_LOW && tx_empty_flag) begin
            tx_buf      <= {tx_data_high, wbyte};
            tx_buf_full <= 1'b1;
        end else if (core_tx_load) begin
            tx_buf_full <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            core_tx_data <= 9'h000;
        else if (core_tx_load)
            core_tx_data <= tx_buf;
    end

    // Sticky status flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            tx_done_flag <= 1'b0;
        else if (core_tx_done && !tx_buf_full)
            tx_done_flag <= 1'b1;
        else if (tx_done_ack || (wr_go && idx == IDX_STATUS && wbyte[ST_TX_DONE]))
            tx_done_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_start_flag <= 1'b0;
            bad_sync_flag <= 1'b0;
            break_flag    <= 1'b0;
        end else begin
            if (core_rx_start)
                rx_start_flag <= 1'b1;
            else if (wr_go && idx == IDX_STATUS && wbyte[ST_RX_START])
                rx_start_flag <= 1'b0;
            if (core_bad_sync || core_autobaud_err)
                bad_sync_flag <= 1'b1;
            else if (wr_go && idx == IDX_STATUS && wbyte[ST_BAD_SYNC])
                bad_sync_flag <= 1'b0;
            if (core_break)
                break_flag <= 1'b1;
            else if (wr_go && idx == IDX_STATUS && wbyte[ST_BREAK])
                break_flag <= 1'b0;
        end
    end

    // Wait-for-break is cleared by the core when the break arrives
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            wait_break <= 1'b0;
        else if (core_break)
            wait_break <= 1'b0;
        else if (wr_go && idx == IDX_STATUS)
            wait_break <= wbyte[ST_WAIT_BREAK];
    end

    // Multiprocessor filter; short characters carry the type in the first stop bit,
    // which is why senders must append a second stop bit
    assign frame_type = (char_size_field == CHAR_SIZE_FIELD_9_LOW || char_size_field == CHAR_SIZE_FIELD_9_HIGH)
                        ? core_rx_data[8] : core_rx_stop1;
    assign rx_accept  = core_rx_valid && rx_enable &&
                        (!multiproc_filter_mode || frame_type);

    // Receive buffer: two entries, entry 0 is next to read
    // Entry: {overflow, frame error, parity error, data[8:0]}
    assign rx_pop           = rd_go && idx == IDX_RX_DATA_LOW && rx_count != 2'd0;
    assign rx_complete_flag = rx_count != 2'd0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_count  <= 2'd0;
            rx_buf[0] <= 12'h000;
            rx_buf[1] <= 12'h000;
        end else if (!rx_enable) begin
            rx_count <= 2'd0;
        end else begin
            unique case ({rx_accept, rx_pop})
                2'b10: begin
                    if (rx_count == 2'd2) begin
                        rx_buf[1][11] <= 1'b1;
                    end else begin
                        rx_buf[rx_count[0]] <= {1'b0, !core_rx_stop1, core_rx_perr, core_rx_data};
                        rx_count            <= rx_count + 2'd1;
                    end
                end
                2'b01: begin
                    rx_buf[0] <= rx_buf[1];
                    rx_count  <= rx_count - 2'd1;
                end
                2'b11: begin
                    if (rx_count == 2'd2) begin
                        rx_buf[0] <= rx_buf[1];
                        rx_buf[1] <= {1'b0, !core_rx_stop1, core_rx_perr, core_rx_data};
                    end else begin
                        rx_buf[0] <= {1'b0, !core_rx_stop1, core_rx_perr, core_rx_data};
                    end
                end
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        unique case (idx)
            IDX_RX_DATA_LOW:  next_rdata = rx_complete_flag ? rx_buf[0][7:0] : 8'h00;
            IDX_RX_DATA_HIGH: next_rdata = {rx_complete_flag, rx_buf[0][11], 3'b000,
                                            rx_buf[0][10], rx_buf[0][9], rx_buf[0][8]};
            IDX_TX_DATA_LOW:  next_rdata = tx_buf[7:0];
            IDX_STATUS:       next_rdata = {rx_complete_flag, tx_done_flag, tx_empty_flag,
                                            rx_start_flag, bad_sync_flag, 1'b0, break_flag, wait_break};
            IDX_IRQ_EN_CTRL:  next_rdata = irq_enable_control;
            IDX_RX_TX_CTRL:   next_rdata = rx_tx_control;
            IDX_FRAME_CTRL:   next_rdata = frame_format_control;
            IDX_BAUD_LOW:     next_rdata = baud_divisor[7:0];
            IDX_BAUD_HIGH:    next_rdata = baud_divisor[15:8];
            IDX_DEBUG_CTRL:   next_rdata = debug_run_control;
            IDX_EVENT_CTRL:   next_rdata = event_input_control;
            IDX_IR_TX_PULSE:  next_rdata = ir_tx_pulse_length;
            IDX_IR_RX_PULSE:  next_rdata = {1'b0, ir_rx_pulse_length};
            default:          next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !bus_ack)
            avs_readdata <= {24'h00_0000, next_rdata};
    end

    // Interrupt vectors are level requests: flag AND enable
    assign rx_complete_vector = (rx_complete_flag && irq_enable_control[EN_RX_COMPLETE]) ||
                                (rx_start_flag && irq_enable_control[EN_RX_START]) ||
                                (bad_sync_flag && irq_enable_control[EN_AUTOBAUD]);
    assign tx_empty_vector    = tx_empty_flag && irq_enable_control[EN_TX_EMPTY];
    assign tx_done_vector     = tx_done_flag && irq_enable_control[EN_TX_DONE];

    // Receive source: event channel takes over from the pin when enabled
    assign raw_rx = infrared_event_input_en ? event_rx_in : rxd_pin_in;

    ume_ir_codec #(
        .PW_W(8)
    ) u_codec (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .ir_enable    (infrared_mode),
        .os_tick      (core_os_tick),
        .tx_bit_start (core_tx_bit_start),
        .tx_width     (ir_tx_pulse_length),
        .rx_min_width (ir_rx_pulse_length),
        .line_tx      (core_txd),
        .line_rx      (raw_rx),
        .pin_tx       (ir_pin_tx),
        .dec_rx       (dec_rx)
    );

    // Loopback feeds the core the driven transmit value ir_pin_tx, not the pin level, so contention shows no mismatch
    assign core_rxd    = irq_enable_control[EN_LOOPBACK] ? ir_pin_tx : dec_rx;
    assign txd_pin_out = ir_pin_tx;
    // Open drain only drives low; otherwise drive whenever the transmitter is on
    assign txd_pin_oe  = tx_enable && (!rx_tx_control[CB_OPEN_DRAIN] || !ir_pin_tx);
endmodule : ume_ext
`default_nettype wire

// ---- common/ume_pkg.sv ----
// Constants for the serial mode extension block: register indices, field positions, encodings.
// Assumes a core frame engine beside it that supplies frames, ticks and status events.
package ume_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_RX_DATA_LOW   = 4'h0;
    localparam logic [3:0] IDX_RX_DATA_HIGH  = 4'h1;
    localparam logic [3:0] IDX_TX_DATA_LOW   = 4'h2;
    localparam logic [3:0] IDX_TX_DATA_HIGH  = 4'h3;
    localparam logic [3:0] IDX_STATUS        = 4'h4;
    localparam logic [3:0] IDX_IRQ_EN_CTRL   = 4'h5;
    localparam logic [3:0] IDX_RX_TX_CTRL    = 4'h6;
    localparam logic [3:0] IDX_FRAME_CTRL    = 4'h7;
    localparam logic [3:0] IDX_BAUD_LOW      = 4'h8;
    localparam logic [3:0] IDX_BAUD_HIGH     = 4'h9;
    localparam logic [3:0] IDX_DEBUG_CTRL    = 4'hB;
    localparam logic [3:0] IDX_EVENT_CTRL    = 4'hC;
    localparam logic [3:0] IDX_IR_TX_PULSE   = 4'hD;
    localparam logic [3:0] IDX_IR_RX_PULSE   = 4'hE;
    // Status bits
    localparam int ST_RX_COMPLETE = 7;
    localparam int ST_TX_DONE     = 6;
    localparam int ST_TX_EMPTY    = 5;
    localparam int ST_RX_START    = 4;
    localparam int ST_BAD_SYNC    = 3;
    localparam int ST_BREAK       = 1;
    localparam int ST_WAIT_BREAK  = 0;
    // Interrupt enable control bits
    localparam int EN_RX_COMPLETE = 7;
    localparam int EN_TX_DONE     = 6;
    localparam int EN_TX_EMPTY    = 5;
    localparam int EN_RX_START    = 4;
    localparam int EN_LOOPBACK    = 3;
    localparam int EN_AUTOBAUD    = 2;
    // Receive/transmit control bits
    localparam int CB_RX_EN       = 7;
    localparam int CB_TX_EN       = 6;
    localparam int CB_START_DET   = 4;
    localparam int CB_OPEN_DRAIN  = 3;
    localparam int CB_RXMODE_LSB  = 1;
    localparam int CB_MULTIPROC   = 0;
    localparam logic [1:0] RXMODE_DOUBLE = 2'h1;
    // Frame format fields
    localparam int FC_COMM_MODE_FIELD_LSB   = 6;
    localparam int FC_PMODE_LSB   = 4;
    localparam int FC_TWO_STOP    = 3;
    localparam logic [1:0] COMM_MODE_FIELD_INFRARED  = 2'h2;
    localparam logic [2:0] CHAR_SIZE_FIELD_9_LOW    = 3'h6;
    localparam logic [2:0] CHAR_SIZE_FIELD_9_HIGH   = 3'h7;
    // Infrared pulse settings
    localparam logic [7:0] TX_PULSE_3_16   = 8'h00;
    localparam logic [7:0] TX_PULSE_OFF    = 8'hFF;
    localparam logic [3:0] OS_PER_BIT      = 4'hF;   // Last tick index of 16 per bit
    localparam logic [3:0] OS_PULSE_TICKS  = 4'h3;   // 3 of 16 ticks
    localparam int EV_INFRARED_IN = 0;
    localparam int DBG_RUN        = 0;
endpackage : ume_pkg

// ---- logic/ume_ir_codec.sv ----
// Infrared pulse encoder and decoder placed between the frame engine and the pins.
// Assumes os_tick is sixteen enables per bit and tx_bit_start marks each transmit bit.
`timescale 1ns/1ps
`default_nettype none
module ume_ir_codec
    import ume_pkg::*;
#(
    parameter int PW_W = 8
) (
    // Clock and reset
    input  wire logic            clk_sys,
    input  wire logic            rst,
    // Control
    input  wire logic            ir_enable,
    input  wire logic            os_tick,
    input  wire logic            tx_bit_start,
    input  wire logic [PW_W-1:0] tx_width,
    input  wire logic [PW_W-2:0] rx_min_width,
    // Serial lines
    input  wire logic            line_tx,
    input  wire logic            line_rx,
    output logic                 pin_tx,
    output logic                 dec_rx
);
    logic [3:0]      tx_ticks;
    logic [PW_W-1:0] tx_clks;
    logic            tx_pulse;
    logic [PW_W-2:0] rx_width;
    logic            rx_taken;
    logic [3:0]      hold_ticks;
    logic            hold_zero;
    logic            rx_pulse;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_ticks <= 4'h0;
            tx_clks  <= '0;
        end else if (tx_bit_start) begin
            tx_ticks <= 4'h0;
            tx_clks  <= '0;
        end else begin
            if (os_tick && tx_ticks != OS_PER_BIT)
                tx_ticks <= tx_ticks + 4'h1;
            if (tx_clks != '1)
                tx_clks <= tx_clks + 1'b1;
        end
    end

    always_comb begin
        unique case (tx_width)
            TX_PULSE_3_16: tx_pulse = !line_tx && (tx_ticks < OS_PULSE_TICKS);
            TX_PULSE_OFF:  tx_pulse = !line_tx;
            default:       tx_pulse = !line_tx && (tx_clks < tx_width);
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            pin_tx <= 1'b1;
        else
            pin_tx <= ir_enable ? !tx_pulse : line_tx;
    end

    // Receive: a low pin level is a pulse; it must last more than rx_min_width clocks to count
    assign rx_pulse = !line_rx;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_width <= '0;
            rx_taken <= 1'b0;
        end else if (!rx_pulse || !ir_enable) begin
            rx_width <= '0;
            rx_taken <= 1'b0;
        end else begin
            if (rx_width != '1)
                rx_width <= rx_width + 1'b1;
            if (rx_width >= rx_min_width)
                rx_taken <= 1'b1;
        end
    end

    // Accepted pulse holds a zero for one bit time; short pulses never start it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_zero  <= 1'b0;
            hold_ticks <= 4'h0;
        end else if (ir_enable && rx_pulse && !rx_taken && rx_width >= rx_min_width) begin
            hold_zero  <= 1'b1;
            hold_ticks <= 4'h0;
        end else if (hold_zero && os_tick) begin
            hold_ticks <= hold_ticks + 4'h1;
            if (hold_ticks == OS_PER_BIT)
                hold_zero <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            dec_rx <= 1'b1;
        else
            dec_rx <= ir_enable ? !hold_zero : line_rx;
    end
endmodule : ume_ir_codec
`default_nettype wire

// ---- verif/ume_ext_props.sv ----
// Checker for the mode extension top: interrupt vectors and transmit hand-off.
// Assumes it is bound onto ume_ext and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ume_ext_props (
    input wire logic clk_sys, rst, avs_read, avs_write, core_tx_ready, tx_enable, core_tx_load,
    input wire logic core_tx_done, tx_done_ack, core_rx_valid, core_rx_start, core_autobaud_err,
    input wire logic core_bad_sync, rx_complete_vector, tx_empty_vector, tx_done_vector
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // One character leaves the buffer per load
    sequence load_s;
        core_tx_load ##1 !core_tx_load;
    endsequence
    load_gate_a: assert property (core_tx_load |-> core_tx_ready && tx_enable && !tx_empty_vector)
        else $error("load without full buffer");
    load_once_a: assert property (core_tx_load |-> load_s)
        else $error("load repeated");
    done_rise_a: assert property ($rose(tx_done_vector) |-> $past(core_tx_done || avs_write))
        else $error("done vector without cause");
    done_clear_a: assert property (tx_done_ack && !core_tx_done |=> !tx_done_vector)
        else $error("done vector not cleared");
    done_hold_a: assert property ($fell(tx_done_vector) |-> $past(tx_done_ack || avs_write))
        else $error("done vector dropped");
    rx_rise_a: assert property ($rose(rx_complete_vector) |->
        $past(core_rx_valid || core_rx_start || core_autobaud_err || core_bad_sync || avs_write))
        else $error("receive vector without cause");
    rx_hold_a: assert property ($fell(rx_complete_vector) |-> $past(avs_read || avs_write))
        else $error("receive vector dropped");
    empty_hold_a: assert property ($fell(tx_empty_vector) |-> $past(avs_write))
        else $error("empty vector dropped");
endmodule : ume_ext_props
bind ume_ext ume_ext_props u_props (.clk_sys, .rst, .avs_read, .avs_write, .core_tx_ready, .tx_enable,
    .core_tx_load, .core_tx_done, .tx_done_ack, .core_rx_valid, .core_rx_start, .core_autobaud_err,
    .core_bad_sync, .rx_complete_vector, .tx_empty_vector, .tx_done_vector);
`default_nettype wire

// ---- verif/ume_peer.sv ----
// Remote sender on the serial bus, seen as finished frames and line events.
// Assumes the caller enters its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ume_peer (
    input  wire logic  clk_sys,
    output logic       rxd_pin_in,
    output logic       core_rx_valid,
    output logic [8:0] core_rx_data,
    output logic       core_rx_stop1,
    output logic       core_rx_start,
    output logic       core_bad_sync,
    output logic       core_autobaud_err
);
    initial {rxd_pin_in, core_rx_valid, core_rx_data, core_rx_stop1} = 12'h800;
    initial {core_rx_start, core_bad_sync, core_autobaud_err} = 3'h0;
    // Sender uses two stop bits, so the first carries the address marker
    task automatic send(input logic [8:0] d, input logic s);
        @(posedge clk_sys);
        {core_rx_valid, core_rx_data, core_rx_stop1} <= {1'b1, d, s};
        @(posedge clk_sys);
        {core_rx_valid, core_rx_data, core_rx_stop1} <= {1'b0, ~d, ~s};
    endtask : send
    task automatic ev(input logic [2:0] m);
        {core_rx_start, core_bad_sync, core_autobaud_err} <= m;
        @(posedge clk_sys);
        {core_rx_start, core_bad_sync, core_autobaud_err} <= 3'h0;
    endtask : ev
endmodule : ume_peer
`default_nettype wire

// ---- verif/ume_ext_bench.sv ----
// Self-checking bench for ume_ext: register calls with expected values.
// Assumes ume_peer feeds received frames and the bench plays the core.
`timescale 1ns/1ps
`default_nettype none
module ume_ext_bench import ume_pkg::*;;
    logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, core_txd = 1, core_tx_ready = 0;
    logic core_tx_done = 0, tx_done_ack = 0, event_rx_in = 1, avs_waitrequest, rxd_pin_in, core_rx_valid;
    logic core_rx_stop1, core_rx_start, core_bad_sync, core_autobaud_err, core_rxd, core_tx_load;
    logic double_speed, rx_complete_vector, tx_empty_vector, tx_done_vector, core_os_tick = 0, core_tx_bit_start = 0;
    logic [5:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [8:0] core_rx_data, core_tx_data;
    logic [7:0] q;
    int miscompares = 0, checked = 0, cycles = 0;
    always #12.5 clk_sys = ~clk_sys;
    ume_ext dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'h1),
        .avs_readdata, .avs_waitrequest, .rxd_pin_in, .event_rx_in, .txd_pin_out(), .txd_pin_oe(), .core_rxd,
        .core_rx_valid, .core_rx_data, .core_rx_stop1, .core_rx_perr(1'b0), .core_rx_start, .core_autobaud_err,
        .core_bad_sync, .core_break(1'b0), .core_txd, .core_tx_ready, .core_tx_done, .core_tx_bit_start,
        .core_os_tick, .core_tx_load, .core_tx_data, .rx_enable(), .tx_enable(), .start_detect_en(),
        .double_speed, .char_size_field(), .two_stop(), .parity_mode(), .baud_divisor(), .run_in_debug(),
        .tx_done_ack, .rx_complete_vector, .tx_empty_vector, .tx_done_vector);
    ume_peer peer (.clk_sys, .rxd_pin_in, .core_rx_valid, .core_rx_data, .core_rx_stop1, .core_rx_start,
        .core_bad_sync, .core_autobaud_err);
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
        {avs_address, avs_writedata, avs_write, avs_read} <= {i, 2'b00, 24'h0, d, w, !w};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        {avs_write, avs_read} <= 2'b00;
        @(posedge clk_sys);
    endtask : bus
    task automatic rd(input logic [3:0] i, input logic [8:0] e);
        bus(1'b0, i, 8'h00);
        chk({1'b0, q}, e);
    endtask : rd
    task automatic vec(input logic [8:0] e);
        @(negedge clk_sys) chk({rx_complete_vector, tx_empty_vector, tx_done_vector}, e);
        @(posedge clk_sys);
    endtask : vec
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(IDX_IRQ_EN_CTRL, 9'h000);
        rd(4'hA, 9'h000);
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h80);
        bus(1'b1, IDX_RX_TX_CTRL, 8'h81);
        peer.send(9'h055, 1'b0);
        vec(9'h000);
        peer.send(9'h0A5, 1'b1);
        vec(9'h004);
        rd(IDX_RX_DATA_LOW, 9'h0A5);
        vec(9'h000);
        bus(1'b1, IDX_RX_TX_CTRL, 8'h80);
        peer.send(9'h033, 1'b0);
        rd(IDX_RX_DATA_LOW, 9'h033);
        bus(1'b1, IDX_FRAME_CTRL, 8'h06);
        bus(1'b1, IDX_RX_TX_CTRL, 8'h81);
        peer.send(9'h0C4, 1'b1);
        peer.send(9'h13C, 1'b0);
        rd(IDX_RX_DATA_LOW, 9'h03C);
        $display("multiprocessor test done");
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h10);
        peer.ev(3'b100);
        vec(9'h004);
        bus(1'b1, IDX_STATUS, 8'h10);
        vec(9'h000);
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h00);
        peer.ev(3'b010);
        bus(1'b0, IDX_STATUS, 8'h00);
        chk({8'h00, q[ST_BAD_SYNC]}, 9'h001);
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h04);
        vec(9'h004);
        $display("event test done");
        bus(1'b1, IDX_RX_TX_CTRL, 8'h40);
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h60);
        vec(9'h002);
        bus(1'b1, IDX_TX_DATA_LOW, 8'h5A);
        vec(9'h000);
        bus(1'b1, IDX_TX_DATA_LOW, 8'h11);
        core_tx_ready <= 1'b1;
        do @(negedge clk_sys); while (core_tx_load !== 1'b1);
        @(posedge clk_sys) core_tx_ready <= 1'b0;
        @(negedge clk_sys) chk(core_tx_data, 9'h05A);
        @(posedge clk_sys) core_tx_done <= 1'b1;
        @(posedge clk_sys) core_tx_done <= 1'b0;
        vec(9'h003);
        tx_done_ack <= 1'b1;
        @(posedge clk_sys) tx_done_ack <= 1'b0;
        vec(9'h002);
        $display("transmit test done");
        event_rx_in <= 1'b0;
        bus(1'b1, IDX_EVENT_CTRL, 8'h01);
        @(negedge clk_sys) chk({8'h00, core_rxd}, 9'h000);
        @(posedge clk_sys);
        bus(1'b1, IDX_IRQ_EN_CTRL, 8'h08);
        for (int b = 0; b < 2; b++) begin
            core_txd <= b[0];
            @(posedge clk_sys);
            @(negedge clk_sys) chk({8'h00, core_rxd}, b);
            @(posedge clk_sys);
        end
        bus(1'b1, IDX_RX_TX_CTRL, 8'h02);
        @(negedge clk_sys) chk({8'h00, double_speed}, 9'h001);
        @(posedge clk_sys);
        bus(1'b1, IDX_FRAME_CTRL, 8'h80);
        @(negedge clk_sys) chk({8'h00, double_speed}, 9'h000);
        @(posedge clk_sys) {core_txd, core_os_tick, core_tx_bit_start} <= 3'b001;
        @(posedge clk_sys) {core_os_tick, core_tx_bit_start} <= 2'b10;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) chk({8'h00, core_rxd}, 9'h001);
        $display("mode test done");
        wrap_up();
    end
endmodule : ume_ext_bench
`default_nettype wire
